// ---- hw/uart_rx_defs.svh ----
// register map, field positions, reset values and timing counts
`ifndef UART_RX_DEFS_SVH
`define UART_RX_DEFS_SVH
`define ADDR_STATUS 8'h00
`define ADDR_BUFFER 8'h04
`define ADDR_CONTROL 8'h08
`define ADDR_DIVISOR 8'h0c
`define ADDR_IRQ_STATUS 8'h10
`define ADDR_IRQ_CLEAR 8'h14
`define ADDR_IRQ_ENABLE 8'h18
`define FLAG_FULL 0
`define FLAG_PARITY 1
`define FLAG_FRAME 2
`define FLAG_OVERRUN 3
`define FLAG_COUNT 4
`define CTRL_RX_EN 0
`define CTRL_PAR_EN 1
`define CTRL_PAR_ODD 2
`define CTRL_RESET 3'h0
`define DIVISOR_RESET 16'h000c
`define OVERSAMPLE 16
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- hw/uart_rx_pkg.sv ----
// types shared by the receive error flag design
package uart_rx_pkg;
   typedef enum logic [4:0] {
      RX_IDLE = 5'h01,
      RX_START = 5'h02,
      RX_DATA = 5'h04,
      RX_PARITY = 5'h08,
      RX_STOP = 5'h10
   } rx_state_type;
   typedef logic [3:0] flag_vec_type;
endpackage

// ---- hw/baud_tick_gen.sv ----
// oversampling tick divider
`timescale 1ns/10ps
module baud_tick_gen #(
   parameter int DIV_W = 16
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic enable, // run the divider
   input wire logic [DIV_W-1:0] divisor, // tick every divisor+1 cycles
   output logic tick // one-cycle enable pulse
);
   logic [DIV_W-1:0] count_reg;

   if (DIV_W < 2 || DIV_W > 32) begin : g_check
      $error("baud_tick_gen: DIV_W out of range");
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !enable) begin
         count_reg <= '0;
         tick <= 1'b0;
      end else if (count_reg >= divisor) begin
         count_reg <= '0;
         tick <= 1'b1;
      end else begin
         count_reg <= count_reg + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule

// ---- hw/rx_frame_receiver.sv ----
// serial frame receiver with three-sample majority vote
`timescale 1ns/10ps
`include "uart_rx_defs.svh"
module rx_frame_receiver #(
   parameter int DATA_BITS = 8,
   parameter int OVERSAMPLE = `OVERSAMPLE
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic tick, // oversampling enable
   input wire logic rx_in, // serial line
   input wire logic enable, // receiver on
   input wire logic parity_en, // frame carries a parity bit
   input wire logic parity_odd, // odd parity when set
   output logic data_done, // pulse: last data bit taken
   output logic frame_done, // pulse: stop bit taken
   output logic [DATA_BITS-1:0] data, // received data, lsb first on line
   output logic parity_bad, // parity mismatch of this frame
   output logic stop_bad // stop bit sampled low
);
   import uart_rx_pkg::*;
   localparam int PW = $clog2(OVERSAMPLE);
   localparam int CW = $clog2(DATA_BITS + 1);
   localparam logic [PW-1:0] LAST = PW'(OVERSAMPLE - 1);
   localparam logic [PW-1:0] DECIDE = PW'(OVERSAMPLE / 2 + 1);
   localparam logic [CW-1:0] LAST_BIT = CW'(DATA_BITS - 1);

   rx_state_type state_reg;
   logic [PW-1:0] phase_reg;
   logic [2:0] vote_reg;
   logic [CW-1:0] bit_cnt_reg;
   logic par_reg;
   logic decide;
   logic bit_val;

   if (DATA_BITS < 5 || DATA_BITS > 9 || OVERSAMPLE < 8) begin : g_check
      $error("rx_frame_receiver: unsupported parameters");
   end

   function automatic logic majority(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   // the vote spans the three ticks around the bit centre
   assign decide = tick && (phase_reg == DECIDE);
   assign bit_val = majority({vote_reg[1:0], rx_in});

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vote_reg <= 3'h7;
      end else if (tick) begin
         vote_reg <= {vote_reg[1:0], rx_in};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || state_reg == RX_IDLE) begin
         phase_reg <= '0;
      end else if (tick) begin
         phase_reg <= (phase_reg == LAST) ? '0 : phase_reg + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= RX_IDLE;
         bit_cnt_reg <= '0;
         par_reg <= 1'b0;
         data <= '0;
         parity_bad <= 1'b0;
         stop_bad <= 1'b0;
         data_done <= 1'b0;
         frame_done <= 1'b0;
      end else begin
         data_done <= 1'b0;
         frame_done <= 1'b0;
         if (!enable) begin
            state_reg <= RX_IDLE;
         end else begin
            unique case (state_reg)
               RX_IDLE: begin
                  if (tick && !rx_in) begin
                     state_reg <= RX_START;
                  end
               end
               RX_START: begin
                  if (decide) begin
                     // a high start sample is noise: wait for the next edge
                     state_reg <= bit_val ? RX_IDLE : RX_DATA;
                     bit_cnt_reg <= '0;
                     par_reg <= 1'b0;
                     parity_bad <= 1'b0;
                  end
               end
               RX_DATA: begin
                  if (decide) begin
                     data <= {bit_val, data[DATA_BITS-1:1]};
                     par_reg <= par_reg ^ bit_val;
                     bit_cnt_reg <= bit_cnt_reg + 1'b1;
                     if (bit_cnt_reg == LAST_BIT) begin
                        data_done <= 1'b1;
                        state_reg <= parity_en ? RX_PARITY : RX_STOP;
                     end
                  end
               end
               RX_PARITY: begin
                  if (decide) begin
                     parity_bad <= (par_reg ^ bit_val) != parity_odd;
                     state_reg <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  if (decide) begin
                     stop_bad <= !bit_val;
                     frame_done <= 1'b1;
                     state_reg <= RX_IDLE;
                  end
               end
            endcase
         end
      end
   end
endmodule

// ---- hw/uart_rx_error_flags.sv ----
// serial receiver error flags with an axi4-lite register slave
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "uart_rx_defs.svh"
module uart_rx_error_flags #(
   parameter int DATA_BITS = 8,
   parameter int DIV_W = 16
) (
   input wire logic aclk, // system clock, 25 MHz
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic serial_rx_pin, // serial line from the remote sender
   output logic rx_irq // receive interrupt, level
);
   import uart_rx_pkg::*;

   // the divisor is written in two byte lanes, so it needs more than eight bits
   if (DATA_BITS < 5 || DATA_BITS > 9 || DIV_W < 9 || DIV_W > 32) begin : g_check
      $error("uart_rx_error_flags: unsupported parameters");
   end

   // status and interrupt vectors share one layout
   uart_rx_pkg::flag_vec_type flag_reg;
   uart_rx_pkg::flag_vec_type armed_reg;
   uart_rx_pkg::flag_vec_type irq_stat_reg;
   uart_rx_pkg::flag_vec_type irq_en_reg;
   uart_rx_pkg::flag_vec_type flag_set;
   uart_rx_pkg::flag_vec_type flag_clr;
   uart_rx_pkg::flag_vec_type flag_next;
   uart_rx_pkg::flag_vec_type irq_clr;

   logic [2:0] ctrl_reg;
   logic [DIV_W-1:0] divisor_reg;
   logic [DATA_BITS-1:0] hold_reg;
   logic discard_reg;

   logic tick;
   logic data_done;
   logic frame_done;
   logic [DATA_BITS-1:0] rx_data;
   logic parity_bad;
   logic stop_bad;

   logic wr_fire;
   logic rd_fire;
   logic status_read;
   logic buffer_read;
   logic drop_now;
   logic load;

   function automatic logic addr_mapped(input logic [7:0] a);
      return a == `ADDR_STATUS || a == `ADDR_BUFFER || a == `ADDR_CONTROL ||
         a == `ADDR_DIVISOR || a == `ADDR_IRQ_STATUS ||
         a == `ADDR_IRQ_CLEAR || a == `ADDR_IRQ_ENABLE;
   endfunction

   function automatic logic [31:0] widen4(input logic [3:0] v);
      return {28'h0000000, v};
   endfunction

   baud_tick_gen #(
      .DIV_W(DIV_W)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(ctrl_reg[`CTRL_RX_EN]),
      .divisor(divisor_reg),
      .tick(tick)
   );

   rx_frame_receiver #(
      .DATA_BITS(DATA_BITS),
      .OVERSAMPLE(`OVERSAMPLE)
   ) u_rx (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .rx_in(serial_rx_pin),
      .enable(ctrl_reg[`CTRL_RX_EN]),
      .parity_en(ctrl_reg[`CTRL_PAR_EN]),
      .parity_odd(ctrl_reg[`CTRL_PAR_ODD]),
      .data_done(data_done),
      .frame_done(frame_done),
      .data(rx_data),
      .parity_bad(parity_bad),
      .stop_bad(stop_bad)
   );

   // bus handshakes: ready pulses one cycle after valid is seen
   assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
   assign rd_fire = s_axi_arready && s_axi_arvalid;
   assign status_read = rd_fire && s_axi_araddr == `ADDR_STATUS;
   assign buffer_read = rd_fire && s_axi_araddr == `ADDR_BUFFER;

   // unread buffer or standing overrun means the arriving frame is dropped
   assign drop_now = flag_reg[`FLAG_FULL] || flag_reg[`FLAG_OVERRUN];
   assign load = frame_done && !discard_reg;

   always_comb begin
      flag_set = '0;
      flag_set[`FLAG_FULL] = load;
      flag_set[`FLAG_PARITY] = load && parity_bad;
      flag_set[`FLAG_FRAME] = load && stop_bad;
      // only the first overrun counts as an event
      flag_set[`FLAG_OVERRUN] = data_done && flag_reg[`FLAG_FULL] &&
         !flag_reg[`FLAG_OVERRUN];
   end

   // a buffer read clears only what the preceding status read saw
   assign flag_clr = buffer_read ? armed_reg : '0;
   // set wins when an event meets the clear in one cycle
   assign flag_next = (flag_reg & ~flag_clr) | flag_set;

   assign irq_clr = (wr_fire && s_axi_awaddr == `ADDR_IRQ_CLEAR && s_axi_wstrb[0]) ?
      s_axi_wdata[`FLAG_COUNT-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed_reg <= '0;
      end else if (status_read) begin
         armed_reg <= flag_reg;
      end else if (buffer_read) begin
         armed_reg <= '0;
      end
   end

   // decision taken once the data bits are in, kept until the stop bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         discard_reg <= 1'b0;
      end else if (data_done) begin
         discard_reg <= drop_now;
      end else if (frame_done) begin
         discard_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_reg <= '0;
      end else if (load) begin
         hold_reg <= rx_data;
      end
   end

   // sticky interrupt status; a new event outlasts a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_reg <= '0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | flag_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_irq <= 1'b0;
      end else begin
         rx_irq <= |(irq_stat_reg & irq_en_reg);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `ADDR_CONTROL) begin
         ctrl_reg <= s_axi_wdata[2:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_en_reg <= '0;
      end else if (wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `ADDR_IRQ_ENABLE) begin
         irq_en_reg <= s_axi_wdata[`FLAG_COUNT-1:0];
      end
   end

   // the low byte of the divisor follows strobe 0, every bit above it follows strobe 1
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         divisor_reg <= DIV_W'(`DIVISOR_RESET);
      end else if (wr_fire && s_axi_awaddr == `ADDR_DIVISOR) begin
         if (s_axi_wstrb[0]) begin
            divisor_reg[7:0] <= s_axi_wdata[7:0];
         end
         if (s_axi_wstrb[1]) begin
            divisor_reg[DIV_W-1:8] <= s_axi_wdata[DIV_W-1:8];
         end
      end
   end

   // write channel: address and data are taken together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !s_axi_awready && !s_axi_bvalid &&
            s_axi_awvalid && s_axi_wvalid;
         s_axi_wready <= !s_axi_awready && !s_axi_bvalid &&
            s_axi_awvalid && s_axi_wvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_mapped(s_axi_awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel: data registered at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= addr_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
         unique case (s_axi_araddr)
            `ADDR_STATUS: s_axi_rdata <= widen4(flag_reg);
            // content after a parity fault is not to be trusted by software
            `ADDR_BUFFER: s_axi_rdata <= 32'(hold_reg);
            `ADDR_CONTROL: s_axi_rdata <= {29'h00000000, ctrl_reg};
            `ADDR_DIVISOR: s_axi_rdata <= 32'(divisor_reg);
            `ADDR_IRQ_STATUS: s_axi_rdata <= widen4(irq_stat_reg);
            `ADDR_IRQ_ENABLE: s_axi_rdata <= widen4(irq_en_reg);
            default: s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ---- testbench/uart_rx_error_flags_assertions.sv ----
// bus and interrupt checks on the receive error flag block
`timescale 1ns/10ps
module uart_rx_checker (
   input wire logic aclk, // clock
   input wire logic aresetn, // reset
   input wire logic [7:0] s_axi_awaddr, // aw addr
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic [31:0] s_axi_wdata, // w data
   input wire logic [3:0] s_axi_wstrb, // w strobes
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic [1:0] s_axi_bresp, // b resp
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [7:0] s_axi_araddr, // ar addr
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // r data
   input wire logic [1:0] s_axi_rresp, // r resp
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready, // r ready
   input wire logic serial_rx_pin, // serial line
   input wire logic rx_irq // interrupt
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   reset_quiet_a: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> !rx_irq && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs busy after reset");
   aw_w_pair_a: assert property (s_axi_awready |-> s_axi_wready && !s_axi_bvalid)
      else $error("write channels not taken together");
   write_answer_a: assert property (s_axi_awready |=> s_axi_bvalid)
      else $error("write response late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   read_answer_a: assert property (s_axi_arready && s_axi_arvalid |=> s_axi_rvalid)
      else $error("read data late");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("read ready longer than a cycle");
   read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   unmapped_read_a: assert property (s_axi_arready && s_axi_araddr >= 8'h1c
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   unmapped_write_a: assert property (s_axi_awready && s_axi_awaddr >= 8'h1c |=> s_axi_bresp == 2'h2)
      else $error("unmapped write not refused");
   irq_mask_a: assert property (s_axi_awready && s_axi_awaddr == 8'h18 && s_axi_wstrb[0]
      && s_axi_wdata[3:0] == 4'h0 |-> ##[1:3] !rx_irq)
      else $error("masked interrupt still high");
   cover property (s_axi_awready && s_axi_awvalid);
   cover property (s_axi_arready && s_axi_araddr >= 8'h1c);
   cover property ($rose(rx_irq));
endmodule
bind uart_rx_error_flags uart_rx_checker u_uart_rx_checker (.*);

// ---- testbench/serial_tx_model.sv ----
// behavioural remote sender driving the serial receive line
`timescale 1ns/10ps
module serial_tx_model #(
   parameter int BIT_CLKS = 16
) (
   input wire logic aclk, // clock
   input wire logic start, // begin one frame
   input wire logic [7:0] data, // payload, lsb first
   input wire logic odd, // odd parity
   input wire logic flip, // send a wrong parity bit
   input wire logic low_stop, // send a low stop bit
   output logic line, // serial line, idle high
   output logic busy // frame in progress
);
   logic [10:0] bits;
   initial begin
      line = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge aclk);
         if (start === 1'b1) begin
            bits = {~low_stop, ^data ^ odd ^ flip, data, 1'b0};
            busy <= 1'b1;
            for (int i = 0; i < 11; i++) begin
               line <= bits[i];
               repeat (BIT_CLKS) @(posedge aclk);
            end
            line <= 1'b1;
            busy <= 1'b0;
         end
      end
   end
endmodule

// ---- testbench/test_uart_rx_error_flags.sv ----
// self-checking bench for the receive error flag block
`timescale 1ns/10ps
module test_uart_rx_error_flags;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tx_data = 8'h00, m_buf = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, seed = 32'h7, got, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, m_flags = 4'h0, m_armed = 4'h0, m_irq = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic serial_rx_pin, tx_busy;
   logic tx_start = 1'b0, tx_odd = 1'b0, tx_flip = 1'b0, tx_low = 1'b0;
   logic [7:0] raddr [5] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h18};
   logic [31:0] rexp [5] = '{32'h0, 32'h0, 32'hc, 32'h0, 32'h0};
   int n_errors = 0, n_checks = 0;
   always #20 aclk = ~aclk;
   uart_rx_error_flags u_uart_rx_error_flags (.*);
   serial_tx_model u_serial_tx_model (.aclk(aclk), .start(tx_start), .data(tx_data), .odd(tx_odd),
      .flip(tx_flip), .low_stop(tx_low), .line(serial_rx_pin), .busy(tx_busy));
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic summarize();
      if (n_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // ready raised a cycle late so the slave must hold its answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_awready !== 1'b1 && ++n < 40);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      @(posedge aclk);
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1 && ++n < 40);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 40) n_errors++;
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1 && ++n < 40);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1 && ++n < 40);
      got = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 40) n_errors++;
      if (a == 8'h00) m_armed = m_flags;
      if (a == 8'h04) begin
         m_flags &= ~m_armed;
         m_armed = 4'h0;
      end
   endtask
   task automatic send(input logic [7:0] d, input logic flip, input logic low);
      int n;
      n = 0;
      @(posedge aclk);
      tx_data <= d;
      tx_flip <= flip;
      tx_low <= low;
      tx_start <= 1'b1;
      @(posedge aclk);
      tx_start <= 1'b0;
      do @(posedge aclk); while (tx_busy !== 1'b0 && ++n < 400);
      repeat (4) @(posedge aclk);
      if (m_flags[3] || m_flags[0]) begin
         if (!m_flags[3]) m_irq[3] = 1'b1;
         m_flags[3] = 1'b1;
      end else begin
         m_buf = d;
         m_flags |= {1'b0, low, flip, 1'b1};
         m_irq |= {1'b0, low, flip, 1'b1};
      end
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      chk("irq at reset", 32'h0, {31'h0, rx_irq});
      foreach (raddr[i]) begin
         rd(raddr[i]);
         chk("reset value", rexp[i], got);
      end
      rd(8'h1c);
      chk("unmapped rresp", 32'h2, {30'h0, resp});
      chk("unmapped rdata", 32'h0, got);
      wr(8'h1c, 32'hffffffff);
      chk("unmapped bresp", 32'h2, {30'h0, resp});
      wr(8'h0c, 32'h0);
      wr(8'h18, 32'hf);
      // good, bad parity, low stop, odd parity mode
      for (int i = 0; i < 4; i++) begin
         tx_odd <= (i == 3);
         wr(8'h08, (i == 3) ? 32'h7 : 32'h3);
         send(xs(), i == 1, i == 2);
         chk("irq raised", 32'h1, {31'h0, rx_irq});
         rd(8'h10);
         chk("irq status", {28'h0, m_irq}, got);
         wr(8'h14, 32'hf);
         m_irq = 4'h0;
         rd(8'h00);
         chk("status", {28'h0, m_flags}, got);
         chk("irq cleared", 32'h0, {31'h0, rx_irq});
         rd(8'h04);
         if (i != 1) chk("buffer", {24'h0, m_buf}, got);
         rd(8'h00);
         chk("status after read", {28'h0, m_flags}, got);
      end
      tx_odd <= 1'b0;
      wr(8'h08, 32'h3);
      send(xs(), 1'b0, 1'b0);
      send(xs(), 1'b0, 1'b0);
      rd(8'h10);
      chk("overrun irq", {28'h0, m_irq}, got);
      wr(8'h14, 32'hf);
      m_irq = 4'h0;
      send(xs(), 1'b1, 1'b1);
      rd(8'h10);
      chk("dropped irq", {28'h0, m_irq}, got);
      rd(8'h00);
      chk("overrun status", {28'h0, m_flags}, got);
      rd(8'h04);
      chk("kept buffer", {24'h0, m_buf}, got);
      rd(8'h00);
      chk("overrun cleared", {28'h0, m_flags}, got);
      send(xs(), 1'b1, 1'b1);
      rd(8'h04);
      rd(8'h00);
      chk("late flags kept", {28'h0, m_flags}, got);
      rd(8'h04);
      rd(8'h00);
      chk("late flags cleared", {28'h0, m_flags}, got);
      wr(8'h14, 32'hf);
      m_irq = 4'h0;
      wr(8'h18, 32'h0);
      send(xs(), 1'b0, 1'b0);
      chk("masked irq", 32'h0, {31'h0, rx_irq});
      wr(8'h18, 32'hf);
      rd(8'h10);
      chk("pending irq", {28'h0, m_irq}, got);
      chk("unmasked irq", 32'h1, {31'h0, rx_irq});
      summarize();
   end
endmodule
